// >>> src/hsmf_pkg.sv
// Constants, types and framing helpers shared by both link ends.
// Assumes both ends run on a 20 MHz mclk and meet in hsmf_link_if.
`default_nettype none
package hsmf_pkg;
	// Clock rate and link timing.
	localparam int CLK_MHZ = 20; // Mclk rate in MHz.
	localparam int TA_US = 200; // Turnaround time in us.
	localparam int TA_CYC = TA_US * CLK_MHZ; // Turnaround in cycles.
	localparam int HALF_NS = 400; // Host serial clock half period in ns.
	localparam int HALF_CYC = (HALF_NS * CLK_MHZ + 999) / 1000;
	localparam logic [11:0] TA_LOAD = 12'(TA_CYC); // Timer load value.
	localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1); // Divider end.
	// Command word fields.
	localparam logic [1:0] DIR_TO_HOST = 2'h1; // Module toward host.
	localparam logic [1:0] DIR_TO_MOD = 2'h2; // Host toward module.
	localparam logic [1:0] CMD_LEN = 2'h2; // Command length field.
	localparam logic [3:0] OP_HSIZE = 4'h9; // Host size exchange.
	localparam logic [3:0] OP_HHDR = 4'ha; // Host header exchange.
	localparam logic [3:0] OP_MSIZE = 4'hb; // Module size exchange.
	localparam logic [3:0] OP_HOST_HEADER_EXCHANGE = 4'hc; // Module header exchange.
	localparam logic [7:0] HDR_BYTE = 8'h01; // Fixed header byte.
	localparam logic [7:0] CMD_BITS = 8'h10; // Bits in a command word.
	// Payload layout.
	localparam logic [7:0] PL_BYTES = 8'h0c; // Payload store and buffer.
	localparam logic [7:0] CONN_LEN = 8'h0c; // Connect payload bytes.
	localparam logic [7:0] ACK_LEN = 8'h08; // Acknowledge payload bytes.
	localparam logic [15:0] CONN_TYPE = 16'h4032; // Connect type code.
	localparam logic [15:0] ACK_TYPE = 16'h0030; // Acknowledge type code.
	localparam logic [31:0] TRAILER = 32'hf0f0a5a5; // Trailing pattern.
	localparam int TRL_BYTES = 4; // Bytes in the trailer.
	localparam int OFS_TYPE = 2; // Type code offset.
	localparam int OFS_FLAG = 4; // Connect flag offset.
	localparam int OFS_CTRL = 8; // Trailer offset in connect.
	localparam int OFS_ATRL = 4; // Trailer offset in acknowledge.
	typedef logic [11:0][7:0] hsmf_pl_t; // Payload, byte 0 sent first.
	typedef logic [15:0][7:0] hsmf_frm_t; // Whole received frame.

	// Builds a command word from direction, opcode and argument byte.
	function automatic logic [15:0] hsmf_cmd(input logic [1:0] dir,
		input logic [3:0] op, input logic [7:0] arg);
		hsmf_cmd = {dir, CMD_LEN, op, arg};
	endfunction

	// Places a 16-bit field into a payload, low byte first.
	function automatic hsmf_pl_t hsmf_put16(input hsmf_pl_t pl,
		input int ofs, input logic [15:0] v);
		hsmf_put16 = pl;
		hsmf_put16[ofs] = v[7:0];
		hsmf_put16[ofs + 1] = v[15:8];
	endfunction

	// Appends the trailer in its fixed serial order.
	function automatic hsmf_pl_t hsmf_put_trl(input hsmf_pl_t pl,
		input int ofs);
		hsmf_put_trl = pl;
		for (int b = 0; b < TRL_BYTES; b++) begin
			hsmf_put_trl[ofs + b] = TRAILER[31 - 8 * b -: 8];
		end
	endfunction

	// Connect payload: length, type, four-byte flag, trailer.
	function automatic hsmf_pl_t hsmf_pl_conn(input logic flag);
		hsmf_pl_t pl;
		pl = hsmf_put16('0, 0, {8'h00, CONN_LEN});
		pl = hsmf_put16(pl, OFS_TYPE, CONN_TYPE);
		pl[OFS_FLAG] = {7'h00, flag};
		hsmf_pl_conn = hsmf_put_trl(pl, OFS_CTRL);
	endfunction

	// Acknowledge payload: length eight, type, trailer.
	function automatic hsmf_pl_t hsmf_pl_ack();
		hsmf_pl_t pl;
		pl = hsmf_put16('0, 0, {8'h00, ACK_LEN});
		pl = hsmf_put16(pl, OFS_TYPE, ACK_TYPE);
		hsmf_pl_ack = hsmf_put_trl(pl, OFS_ATRL);
	endfunction

	// Byte k of a frame; past the payload everything is zero.
	function automatic logic [7:0] hsmf_frame_byte(input logic [15:0] cmd,
		input hsmf_pl_t pl, input logic [7:0] k);
		logic [7:0] i;
		i = k - 8'h02;
		if (k == 8'h00) begin
			hsmf_frame_byte = cmd[15:8];
		end else if (k == 8'h01) begin
			hsmf_frame_byte = cmd[7:0];
		end else if (i < PL_BYTES) begin
			hsmf_frame_byte = pl[i[3:0]];
		end else begin
			hsmf_frame_byte = 8'h00;
		end
	endfunction

	// Bit n of a frame, each byte sent most significant bit first.
	function automatic logic hsmf_frame_bit(input logic [15:0] cmd,
		input hsmf_pl_t pl, input logic [7:0] n);
		logic [7:0] b;
		b = hsmf_frame_byte(cmd, pl, {3'h0, n[7:3]});
		hsmf_frame_bit = b[3'h7 - n[2:0]];
	endfunction
endpackage
`default_nettype wire

// >>> src/hsmf_link_if.sv
// Link between the host end and the module end of the framer.
// Assumes weak pulls: select idles high, clock and data idle low.
`timescale 1ns/1ns
`default_nettype none
interface hsmf_link_if;
	logic wake; // Wake request line, host to module.
	logic ready; // Slave ready line, module to host.
	logic attn; // Slave attention line, module to host.
	logic host_oe; // Host drives select, clock and host data.
	logic cs_n_o; // Select driven by the host.
	logic sclk_o; // Serial clock driven by the host.
	logic mosi_o; // Host data driven by the host.
	logic miso_o; // Module data driven by the module.
	logic miso_oe; // Module drives its data line.
	logic cs_n; // Resolved select.
	logic sclk; // Resolved serial clock.
	logic mosi; // Resolved host data.
	logic miso; // Resolved module data.
	// Undriven lines fall to their pull level.
	assign cs_n = host_oe ? cs_n_o : 1'h1;
	assign sclk = host_oe ? sclk_o : 1'h0;
	assign mosi = host_oe ? mosi_o : 1'h0;
	assign miso = miso_oe ? miso_o : 1'h0;
	modport host (output wake, host_oe, cs_n_o, sclk_o, mosi_o,
		input ready, attn, miso);
	modport dev (input wake, cs_n, sclk, mosi,
		output ready, attn, miso_o, miso_oe);
endinterface
`default_nettype wire

// >>> src/hsmf_host_end.sv
// Host end of the framer: SPI master that sends connect messages
// and collects the module's messages.
// Assumes the module end on the other side of hsmf_link_if.
`timescale 1ns/1ns
`default_nettype none
module hsmf_host_end import hsmf_pkg::*; (
	input wire logic mclk, // System clock.
	input wire logic reset, // Asynchronous reset, active high.
	hsmf_link_if.host link, // Link to the module.
	input wire logic send_req, // Pulse: send a connect message.
	input wire logic send_flag, // Connect flag value with the request.
	output logic pending, // A connect message awaits delivery.
	output logic sent, // Pulse: connect message delivered.
	output logic ack_seen, // Pulse: module acknowledge received.
	output logic proto_err // Sticky: malformed answer seen.
);
	// Host sequencer states.
	typedef enum logic [2:0] {H_IDLE = 3'b000, H_WAKE = 3'b001,
		H_XFER = 3'b010, H_CHK = 3'b011, H_TURN = 3'b100} hsmf_hst_t;
	// Synchronised link inputs.
	typedef struct packed {logic ready; logic attn; logic miso;} hsmf_hpin_t;
	// Whole state of the host end.
	typedef struct packed {
		hsmf_hst_t st; hsmf_hpin_t s1; hsmf_hpin_t s2;
		logic req; logic flag; logic mode; logic step;
		logic wake; logic oe; logic cs_n; logic sclk; logic mosi;
		logic [3:0] div; logic [7:0] cnt; logic [7:0] nbits;
		logic [11:0] tmr; hsmf_frm_t rx;
		logic sent; logic ack; logic err;
	} hsmf_hstate_t;
	hsmf_hstate_t r_ff; // Registered state.
	hsmf_hstate_t nxt_r; // Next state.
	logic [15:0] tx_cmd; // Command word of the current exchange.
	hsmf_pl_t tx_pl; // Payload of the current exchange.
	logic [15:0] rx_cmd; // Command word received.
	hsmf_pl_t ack_pl; // Acknowledge payload the module must send.

	// Next-state logic for sequencer and bit engine.
	always_comb begin
		nxt_r = r_ff;
		nxt_r.s1 = '{ready: link.ready, attn: link.attn, miso: link.miso};
		nxt_r.s2 = r_ff.s1;
		nxt_r.sent = 1'h0;
		nxt_r.ack = 1'h0;
		rx_cmd = {r_ff.rx[0], r_ff.rx[1]};
		ack_pl = hsmf_pl_ack();
		tx_pl = '0;
		// Mode one is a module message, step one its header exchange.
		if (!r_ff.mode && !r_ff.step) begin
			tx_cmd = hsmf_cmd(DIR_TO_MOD, OP_HSIZE, CONN_LEN);
		end else if (!r_ff.mode) begin
			tx_cmd = hsmf_cmd(DIR_TO_MOD, OP_HHDR, HDR_BYTE);
			tx_pl = hsmf_pl_conn(r_ff.flag);
		end else if (!r_ff.step) begin
			tx_cmd = hsmf_cmd(DIR_TO_MOD, OP_MSIZE, PL_BYTES);
		end else begin
			tx_cmd = hsmf_cmd(DIR_TO_MOD, OP_HOST_HEADER_EXCHANGE, HDR_BYTE);
		end
		// A new request is latched once.
		if (send_req && !r_ff.req) begin
			nxt_r.req = 1'h1;
			nxt_r.flag = send_flag;
		end
		unique case (r_ff.st)
			H_IDLE: begin
				// Module attention is served before own messages.
				// A new start waits until ready has been seen low, so a
				// stale ready from the last message cannot open a transfer.
				if ((r_ff.s2.attn || r_ff.req) && !r_ff.s2.ready) begin
					nxt_r.mode = r_ff.s2.attn;
					nxt_r.step = 1'h0;
					nxt_r.nbits = CMD_BITS;
					nxt_r.wake = 1'h1;
					nxt_r.oe = 1'h1;
					nxt_r.cs_n = 1'h1;
					nxt_r.st = H_WAKE;
				end
			end
			H_WAKE: begin
				// No clocking before the module reports ready.
				if (r_ff.s2.ready) begin
					nxt_r.cs_n = 1'h0;
					nxt_r.sclk = 1'h0;
					nxt_r.div = '0;
					nxt_r.cnt = '0;
					nxt_r.rx = '0;
					nxt_r.mosi = hsmf_frame_bit(tx_cmd, tx_pl, 8'h00);
					nxt_r.st = H_XFER;
				end
			end
			H_XFER: begin
				if (r_ff.div != HALF_LAST) begin
					nxt_r.div = r_ff.div + 4'h1;
				end else if (!r_ff.sclk) begin
					nxt_r.div = '0;
					nxt_r.sclk = 1'h1;
				end else begin
					// Sample at the end of the high phase, then fall.
					nxt_r.div = '0;
					nxt_r.rx[r_ff.cnt[6:3]][3'h7 - r_ff.cnt[2:0]] = r_ff.s2.miso;
					nxt_r.sclk = 1'h0;
					nxt_r.cnt = r_ff.cnt + 8'h01;
					if (r_ff.cnt + 8'h01 == r_ff.nbits) begin
						nxt_r.cs_n = 1'h1;
						nxt_r.st = H_CHK;
					end else begin
						nxt_r.mosi = hsmf_frame_bit(tx_cmd, tx_pl, r_ff.cnt + 8'h01);
					end
				end
			end
			H_CHK: begin
				// Judge the answer and plan the next step.
				nxt_r.tmr = TA_LOAD;
				nxt_r.st = H_TURN;
				nxt_r.step = 1'h0;
				if (!r_ff.step && !r_ff.mode) begin
					if (rx_cmd != hsmf_cmd(DIR_TO_HOST, OP_HSIZE, rx_cmd[7:0])) begin
						nxt_r.err = 1'h1;
					end else if (rx_cmd[7:0] >= CONN_LEN) begin
						nxt_r.step = 1'h1;
						nxt_r.nbits = CMD_BITS + {CONN_LEN[4:0], 3'h0};
					end
				end else if (!r_ff.step) begin
					if (rx_cmd == hsmf_cmd(DIR_TO_HOST, OP_MSIZE, rx_cmd[7:0]) &&
						rx_cmd[7:0] <= PL_BYTES) begin
						nxt_r.step = 1'h1;
						nxt_r.nbits = CMD_BITS + {rx_cmd[4:0], 3'h0};
					end else begin
						nxt_r.err = 1'h1;
					end
				end else if (!r_ff.mode) begin
					if (rx_cmd == hsmf_cmd(DIR_TO_HOST, OP_HHDR, HDR_BYTE)) begin
						nxt_r.req = 1'h0;
						nxt_r.sent = 1'h1;
					end else begin
						nxt_r.err = 1'h1;
					end
				end else if (rx_cmd == hsmf_cmd(DIR_TO_HOST, OP_HOST_HEADER_EXCHANGE, HDR_BYTE)
					&& r_ff.rx[9:2] == ack_pl[7:0]) begin
					nxt_r.ack = 1'h1;
				end else begin
					nxt_r.err = 1'h1;
				end
			end
			H_TURN: begin
				// Turnaround, then the next step or release of the bus.
				if (r_ff.tmr != '0) begin
					nxt_r.tmr = r_ff.tmr - 12'h001;
				end else if (r_ff.step) begin
					nxt_r.st = H_WAKE;
				end else begin
					nxt_r.wake = 1'h0;
					nxt_r.oe = 1'h0;
					nxt_r.st = H_IDLE;
				end
			end
			default: nxt_r.st = H_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			r_ff <= '{st: H_IDLE, cs_n: 1'h1, default: '0};
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign link.wake = r_ff.wake;
	assign link.host_oe = r_ff.oe;
	assign link.cs_n_o = r_ff.cs_n;
	assign link.sclk_o = r_ff.sclk;
	assign link.mosi_o = r_ff.mosi;
	assign pending = r_ff.req;
	assign sent = r_ff.sent;
	assign ack_seen = r_ff.ack;
	assign proto_err = r_ff.err;
endmodule // hsmf_host_end
`default_nettype wire

// >>> src/hsmf_module_end.sv
// Module end of the framer: SPI slave that takes host messages,
// recognises connect and answers it with its own acknowledge message.
// Assumes the host end across hsmf_link_if; all link pins are
// asynchronous to mclk and pass two flip-flops first.
`timescale 1ns/1ns
`default_nettype none
module hsmf_module_end import hsmf_pkg::*; (
	input wire logic mclk, // System clock.
	input wire logic reset, // Asynchronous reset, active high.
	hsmf_link_if.dev link, // Link to the host.
	output logic unsol_en, // Host allowed unsolicited messages.
	output logic conn_seen, // Pulse: connect message taken.
	output logic ack_sent, // Pulse: acknowledge message delivered.
	output logic proto_err // Sticky: malformed command word seen.
);
	// Exchange phase expected for the next transfer.
	typedef enum logic [1:0] {
		MP_SIZE = 2'b00, // Next transfer is a size exchange.
		MP_HIN = 2'b01, // Next is a host header with payload.
		MP_HOUT = 2'b10 // Next is the module header with payload.
	} hsmf_mph_t;

	// Link pins as seen through the synchroniser.
	typedef struct packed {
		logic wake; // Wake request line.
		logic cs_n; // Select, active low.
		logic sclk; // Serial clock.
		logic mosi; // Host data.
	} hsmf_mpin_t;

	// Whole state of the module end.
	typedef struct packed {
		hsmf_mph_t ph; // Expected phase.
		hsmf_mpin_t s1; // First synchroniser stage.
		hsmf_mpin_t s2; // Second synchroniser stage.
		logic sclk_d; // Clock one cycle later, for edges.
		logic cs_d; // Select one cycle later, for edges.
		logic [7:0] cnt; // Bits received in this transfer.
		hsmf_frm_t rx; // Received frame bytes.
		logic miso; // Module data bit on the line.
		logic miso_oe; // Module drives its data line.
		logic ready; // Slave ready line.
		logic attn; // Slave attention line.
		logic pend; // Acknowledge message waiting to go.
		logic unsol; // Unsolicited messages enabled.
		logic conn; // Connect pulse.
		logic sent; // Acknowledge delivered pulse.
		logic err; // Sticky protocol error.
		logic [11:0] tmr; // Turnaround timer.
	} hsmf_mstate_t;

	hsmf_mstate_t r_ff; // Registered state.
	hsmf_mstate_t nxt_r; // Next state.
	logic [15:0] tx_cmd; // Command word this end sends now.
	hsmf_pl_t tx_pl; // Payload this end sends now.
	logic [15:0] rx_cmd; // Command word received from the host.
	hsmf_pl_t rx_pl; // Payload received from the host.
	logic cs_fall; // Select has just gone low.
	logic cs_rise; // Select has just gone high.
	logic sclk_rise; // Serial clock rising inside a transfer.
	logic sclk_fall; // Serial clock falling inside a transfer.
	logic conn_ok; // Received payload is a well-formed connect.

	// Edges are taken only from the second synchroniser stage.
	always_comb begin
		cs_fall = r_ff.cs_d && !r_ff.s2.cs_n;
		cs_rise = !r_ff.cs_d && r_ff.s2.cs_n;
		sclk_rise = !r_ff.sclk_d && r_ff.s2.sclk && !r_ff.s2.cs_n;
		sclk_fall = r_ff.sclk_d && !r_ff.s2.sclk && !r_ff.s2.cs_n;
	end

	// Selects what this end shifts out in the expected phase.
	always_comb begin
		tx_pl = '0;
		unique case (r_ff.ph)
			MP_SIZE: begin
				// A waiting acknowledge announces its size, else the
				// free buffer space is offered.
				if (r_ff.pend) begin
					tx_cmd = hsmf_cmd(DIR_TO_HOST, OP_MSIZE, ACK_LEN);
				end else begin
					tx_cmd = hsmf_cmd(DIR_TO_HOST, OP_HSIZE, PL_BYTES);
				end
			end
			MP_HIN: begin
				// Only the header goes out; the rest is zero fill.
				tx_cmd = hsmf_cmd(DIR_TO_HOST, OP_HHDR, HDR_BYTE);
			end
			MP_HOUT: begin
				// Header followed by the acknowledge payload.
				tx_cmd = hsmf_cmd(DIR_TO_HOST, OP_HOST_HEADER_EXCHANGE, HDR_BYTE);
				tx_pl = hsmf_pl_ack();
			end
			default: begin
				tx_cmd = '0;
			end
		endcase
	end

	// Splits the received frame and checks a connect payload.
	always_comb begin
		rx_cmd = {r_ff.rx[0], r_ff.rx[1]};
		rx_pl = r_ff.rx[13:2];
		// Only flag values zero and one form a valid connect.
		conn_ok = (rx_pl == hsmf_pl_conn(1'h1)) ||
			(rx_pl == hsmf_pl_conn(1'h0));
	end

	// Next-state logic: synchroniser, bit engine and phase sequence.
	always_comb begin
		nxt_r = r_ff;
		nxt_r.s1 = '{wake: link.wake, cs_n: link.cs_n, sclk: link.sclk,
			mosi: link.mosi};
		nxt_r.s2 = r_ff.s1;
		nxt_r.sclk_d = r_ff.s2.sclk;
		nxt_r.cs_d = r_ff.s2.cs_n;
		nxt_r.conn = 1'h0;
		nxt_r.sent = 1'h0;
		// Ready follows the wake request of the host.
		nxt_r.ready = r_ff.s2.wake;
		// Drive the data line only while selected.
		nxt_r.miso_oe = !r_ff.s2.cs_n;
		// The turnaround timer runs down between steps.
		if (r_ff.tmr != '0) begin
			nxt_r.tmr = r_ff.tmr - 12'h001;
		end
		// Attention is raised only once the turnaround has passed.
		nxt_r.attn = r_ff.pend && (r_ff.tmr == '0);
		if (cs_fall) begin
			// Present the first bit before the first rising edge.
			nxt_r.cnt = '0;
			nxt_r.rx = '0;
			nxt_r.miso = hsmf_frame_bit(tx_cmd, tx_pl, 8'h00);
		end else if (sclk_rise) begin
			// Capture host data on the rising edge; excess bits drop.
			if (!r_ff.cnt[7]) begin
				nxt_r.rx[r_ff.cnt[6:3]][3'h7 - r_ff.cnt[2:0]] = r_ff.s2.mosi;
				nxt_r.cnt = r_ff.cnt + 8'h01;
			end
		end else if (sclk_fall) begin
			// Change module data on the falling edge.
			nxt_r.miso = hsmf_frame_bit(tx_cmd, tx_pl, r_ff.cnt);
		end
		if (cs_rise) begin
			// End of a transfer: judge it and start the turnaround.
			nxt_r.tmr = TA_LOAD;
			nxt_r.ph = MP_SIZE;
			unique case (r_ff.ph)
				MP_SIZE: begin
					if (rx_cmd == hsmf_cmd(DIR_TO_MOD, OP_HSIZE, rx_cmd[7:0])) begin
						// An oversize request is left for the host to retry.
						if (rx_cmd[7:0] <= PL_BYTES) begin
							nxt_r.ph = MP_HIN;
						end
					end else if (r_ff.pend &&
						rx_cmd == hsmf_cmd(DIR_TO_MOD, OP_MSIZE, rx_cmd[7:0])) begin
						nxt_r.ph = MP_HOUT;
					end else begin
						nxt_r.err = 1'h1;
					end
				end
				MP_HIN: begin
					if (rx_cmd != hsmf_cmd(DIR_TO_MOD, OP_HHDR, HDR_BYTE)) begin
						nxt_r.err = 1'h1;
					end else if (conn_ok) begin
						// Flag byte zero carries the enable, low byte first.
						nxt_r.unsol = rx_pl[OFS_FLAG][0];
						nxt_r.pend = 1'h1;
						nxt_r.conn = 1'h1;
					end
				end
				MP_HOUT: begin
					if (rx_cmd == hsmf_cmd(DIR_TO_MOD, OP_HOST_HEADER_EXCHANGE, HDR_BYTE)) begin
						nxt_r.pend = 1'h0;
						nxt_r.sent = 1'h1;
					end else begin
						nxt_r.err = 1'h1;
					end
				end
				default: begin
					nxt_r.err = 1'h1;
				end
			endcase
		end
	end

	// State register; select idles high after reset.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			r_ff <= '{ph: MP_SIZE, s1: '{cs_n: 1'h1, default: 1'h0},
				s2: '{cs_n: 1'h1, default: 1'h0}, cs_d: 1'h1, default: '0};
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Link and user outputs come straight from the state register.
	assign link.ready = r_ff.ready;
	assign link.attn = r_ff.attn;
	assign link.miso_o = r_ff.miso;
	assign link.miso_oe = r_ff.miso_oe;
	assign unsol_en = r_ff.unsol;
	assign conn_seen = r_ff.conn;
	assign ack_sent = r_ff.sent;
	assign proto_err = r_ff.err;
endmodule // hsmf_module_end
`default_nettype wire

// >>> verif/hsmf_link_properties.sv
// Concurrent checks on the resolved lines of the framer link.
// Assumes one host end and one module end joined by hsmf_link_if.
`timescale 1ns/1ns
`default_nettype none
module hsmf_link_properties import hsmf_pkg::*; (
	input wire logic mclk, // System clock.
	input wire logic reset, // Asynchronous reset, active high.
	input wire logic wake, // Wake request line.
	input wire logic ready, // Slave ready line.
	input wire logic attn, // Slave attention line.
	input wire logic cs_n, // Resolved select, active low.
	input wire logic sclk, // Resolved serial clock.
	input wire logic mosi, // Resolved host data.
	input wire logic miso // Resolved module data.
);
	logic sclk_ff; // Serial clock one cycle ago.
	logic [7:0] mo_ff; // Opening host byte of a transfer.
	logic [7:0] mi_ff; // Opening module byte of a transfer.
	logic [3:0] nb_ff; // Opening bits seen so far.
	logic [15:0] gap_ff; // Cycles with select high, saturating.
	logic [3:0] last_ff; // Host opcode of the previous transfer.
	logic cs_ff; // Select one cycle ago.
	// Gathers the opening byte of each line and the idle gap.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			sclk_ff <= 1'h0;
			cs_ff <= 1'h1;
			mo_ff <= 8'h00;
			mi_ff <= 8'h00;
			nb_ff <= 4'h0;
			gap_ff <= 16'hffff; // The first transfer needs no gap.
			last_ff <= 4'h0;
		end else begin
			sclk_ff <= sclk;
			cs_ff <= cs_n;
			if (cs_n) begin
				nb_ff <= 4'h0;
				gap_ff <= (gap_ff == 16'hffff) ? gap_ff : gap_ff + 16'h1;
			end else begin
				gap_ff <= 16'h0000;
				if (sclk && !sclk_ff && nb_ff < 4'h8) begin
					mo_ff <= {mo_ff[6:0], mosi};
					mi_ff <= {mi_ff[6:0], miso};
					nb_ff <= nb_ff + 4'h1;
				end
			end
			if (cs_n && !cs_ff) begin
				last_ff <= mo_ff[3:0]; // Remembered once a transfer ends.
			end
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	chk_clk_idle_low: assert property (cs_n |-> !sclk)
		else $error("Serial clock high while deselected.");
	chk_select_needs_ready: assert property ($fell(cs_n) |-> wake && ready)
		else $error("Select fell without wake and ready.");
	chk_ready_follows_wake: assert property (
		$rose(wake) |-> !ready ##[1:5] ready)
		else $error("Ready did not follow wake.");
	chk_idle_without_wake: assert property (!wake |-> cs_n)
		else $error("Select low without wake.");
	chk_clk_high_time: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
		else $error("Serial clock high phase has the wrong length.");
	chk_mosi_steady_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
		else $error("Host data moved while clock high.");
	chk_miso_steady_high: assert property (sclk && $past(sclk) |-> $stable(miso))
		else $error("Module data moved while clock high.");
	chk_dir_len_fields: assert property ($rose(cs_n) |-> nb_ff == 4'h8 && mo_ff[7:4] == 4'ha && mi_ff[7:4] == 4'h6)
		else $error("Direction or length field wrong.");
	chk_opcode_pair: assert property ($rose(cs_n) |-> mo_ff[3:0] == mi_ff[3:0] || (mo_ff[3:0] == OP_HSIZE && mi_ff[3:0] == OP_MSIZE))
		else $error("Opcodes of a pair disagree.");
	chk_size_then_header: assert property ($rose(cs_n) && mo_ff[3:0] == OP_HHDR |-> last_ff == OP_HSIZE)
		else $error("Header exchange without size exchange.");
	chk_turnaround_gap: assert property ($fell(cs_n) |-> gap_ff >= 16'(TA_CYC - 2))
		else $error("Turnaround too short.");
	cover property ($rose(attn));
	cover property ($rose(cs_n) && mo_ff[3:0] == OP_HOST_HEADER_EXCHANGE);
	cover property ($fell(wake));
endmodule // hsmf_link_properties
`default_nettype wire

// >>> verif/host_spi_message_framer_test.sv
// Bench: host end and module end meet over one link; connects go out.
// Assumes the package constants; the checker sits beside the link.
`timescale 1ns/1ns
`default_nettype none
module host_spi_message_framer_test import hsmf_pkg::*;;
	typedef struct {int n; logic [127:0] mo; logic [127:0] mi;} hsmf_exp_t;
	logic mclk, reset, send_req, send_flag, f; // Drives of the host end.
	logic pending, sent, ack_seen, host_err; // Host end outputs.
	logic unsol_en, conn_seen, ack_sent, mod_err; // Module end outputs.
	int fail_count, checked, cyc, nb, n_sent, n_ack, n_conn, n_done;
	hsmf_exp_t fq[$]; // Expected transfers, oldest first.
	logic uq[$]; // Expected connect flags, oldest first.
	logic exp_u, sclk_q, cs_q; // Last flag taken, lines one sample ago.
	logic [127:0] mo, mi; // Bits of the current transfer.
	hsmf_link_if link();
	hsmf_host_end i_hsmf_host_end(.mclk(mclk), .reset(reset), .link(link),
		.send_req(send_req), .send_flag(send_flag), .pending(pending),
		.sent(sent), .ack_seen(ack_seen), .proto_err(host_err));
	hsmf_module_end i_hsmf_module_end(.mclk(mclk), .reset(reset),
		.link(link), .unsol_en(unsol_en), .conn_seen(conn_seen),
		.ack_sent(ack_sent), .proto_err(mod_err));
	hsmf_link_properties i_hsmf_link_properties(.mclk(mclk), .reset(reset),
		.wake(link.wake), .ready(link.ready), .attn(link.attn),
		.cs_n(link.cs_n), .sclk(link.sclk), .mosi(link.mosi),
		.miso(link.miso));
	// Compares a single output bit.
	task automatic cmp_bit(input logic got, input logic exp, input string s);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s is %b", $time, s, got);
		end
	endtask
	// Compares a count of events seen.
	task automatic cmp_count(input int got, input int exp, input string s);
		checked++;
		if (got != exp) begin
			fail_count++;
			$display("mismatch at %0t: %s is %0d", $time, s, got);
		end
	endtask
	// Compares a finished transfer with the oldest expected one.
	task automatic cmp_frame(input hsmf_exp_t e);
		checked++;
		if (nb != e.n || mo !== e.mo || mi !== e.mi) begin
			fail_count++;
			$display("mismatch at %0t: %0d bits %h %h", $time, nb, mo, mi);
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Requests one connect, with a refused second request while pending.
	task automatic send(input logic v);
		hsmf_exp_t e;
		e = '{16, 128'h0a90c, 128'h0690c};
		fq.push_back(e);
		e = '{112, 128'({16'haa01, 8'h0c, 8'h00, 8'h32, 8'h40, 7'h00, v,
			24'h000000, 32'hf0f0a5a5}), 128'({16'h6a01, 96'h0})};
		fq.push_back(e);
		e = '{16, 128'h0ab0c, 128'h06b08};
		fq.push_back(e);
		e = '{80, 128'({16'hac01, 64'h0}), 128'({16'h6c01, 8'h08, 8'h00,
			ACK_TYPE[7:0], ACK_TYPE[15:8], 32'hf0f0a5a5})};
		fq.push_back(e);
		uq.push_back(v);
		send_req = 1'h1;
		send_flag = v;
		@(negedge mclk);
		cmp_bit(pending, 1'h1, "pending");
		send_flag = ~v; // This request must be ignored.
		@(negedge mclk);
		send_req = 1'h0;
	endtask
	// Makes the 20 MHz clock.
	initial begin
		mclk = 1'h0;
		forever #25 mclk = ~mclk;
	end
	// Cuts a hang short.
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 100000) begin
			fail_count++;
			$display("mismatch at %0t: run timed out", $time);
			finish_test();
		end
	end
	// Watches outputs and the link; compares against the queues.
	always @(negedge mclk) begin
		if (!reset) begin
			if (conn_seen === 1'h1) begin
				n_conn++;
				exp_u = (uq.size() > 0) ? uq.pop_front() : 1'hx;
			end
			if (ack_sent === 1'h1) begin
				n_done++;
				cmp_bit(unsol_en, exp_u, "unsol_en");
			end
			if (sent === 1'h1) begin
				cmp_bit(pending, 1'h0, "pending after sent");
			end
			n_sent += (sent === 1'h1) ? 1 : 0;
			n_ack += (ack_seen === 1'h1) ? 1 : 0;
			if (cs_q && !link.cs_n) begin
				nb = 0;
				mo = '0;
				mi = '0;
			end
			if (link.sclk && !sclk_q && !link.cs_n) begin
				mo = {mo[126:0], link.mosi};
				mi = {mi[126:0], link.miso};
				nb++;
			end
			if (!cs_q && link.cs_n) begin
				if (fq.size() == 0) begin
					cmp_count(nb, 0, "unexpected transfer");
				end else begin
					cmp_frame(fq.pop_front());
				end
			end
		end
		sclk_q = link.sclk;
		cs_q = link.cs_n;
	end
	// Main sequence: reset, then two connects with opposite flags.
	initial begin
		reset = 1'h1;
		send_req = 1'h0;
		send_flag = 1'h0;
		sclk_q = 1'h0;
		cs_q = 1'h1;
		void'($urandom(32'h9993e69b));
		repeat (16) @(negedge mclk);
		reset = 1'h0;
		f = 1'($urandom());
		for (int r = 0; r < 2; r++) begin
			send(f);
			for (int w = 0; w < 45000 && n_ack <= r; w++) @(negedge mclk);
			f = ~f;
		end
		repeat (200) @(negedge mclk);
		cmp_count(n_sent, 2, "sent pulses");
		cmp_count(n_conn, 2, "connects taken");
		cmp_count(n_done, 2, "acks sent");
		cmp_count(n_ack, 2, "acks seen");
		cmp_count(fq.size(), 0, "missing transfers");
		cmp_bit(host_err, 1'h0, "host error");
		cmp_bit(mod_err, 1'h0, "module error");
		finish_test();
	end
endmodule // host_spi_message_framer_test
`default_nettype wire
